// >>> shared/pmon_pkg.sv
package pmon_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_MS = 1000;
  localparam int BLINK_MS = 500;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
  localparam logic [15:0] SLOW_RPM = 16'h003C;
  localparam logic [15:0] ZERO_RPM = 16'h0000;
  localparam logic [7:0] TEMP_WARN_MOTOR = 8'h50;
  localparam logic [7:0] TEMP_ERR_MOTOR = 8'h5A;
  localparam logic [7:0] TEMP_WARN_ELEC = 8'h46;
  localparam logic [7:0] TEMP_ERR_ELEC = 8'h50;
  localparam logic [15:0] DIRECT_VENT_S = 16'h0006;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ACK = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CODE = 8'h0C;
  localparam logic [7:0] ADDR_ERRS = 8'h10;
  localparam logic [7:0] ADDR_SPEED_SW = 8'h14;
  localparam logic [7:0] ADDR_TARGET = 8'h18;
  localparam logic [7:0] ADDR_RUNUP = 8'h1C;
  localparam logic [7:0] ADDR_VENT = 8'h20;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_VMODE = 1;
  localparam int ACK_BIT = 0;
  localparam logic [15:0] RST_SPEED_SW = 16'h2EE0;
  localparam logic [15:0] RST_TARGET = 16'h3A98;
  localparam logic [15:0] RST_RUNUP_S = 16'h0258;
  localparam logic [15:0] RST_VENT_S = 16'h000A;
  localparam logic [1:0] VM_DELAYED = 2'h0;
  localparam logic [1:0] VM_NONE = 2'h1;
  localparam logic [1:0] VM_DIRECT = 2'h2;
  localparam int ERR_N = 10;
  localparam int E_OVERSPEED = 0;
  localparam int E_OVERVOLT = 1;
  localparam int E_RUNUP = 2;
  localparam int E_TEMP_ELEC = 8;
  localparam int E_TEMP_MOTOR = 9;
  localparam logic [ERR_N-1:0] ZERO_ACK_MASK = 10'h0FB;
  localparam logic [ERR_N-1:0][7:0] ERR_CODE = {8'h2D, 8'h2C, 8'h29, 8'h15, 8'h0A,
                                                8'h08, 8'h07, 8'h06, 8'h02, 8'h01};
  typedef struct packed {
    logic [15:0] speed;
    logic [7:0] temp_motor;
    logic [7:0] temp_elec;
    logic [6:0] fault;
    logic selftest;
  } pmon_sense_s;
  typedef enum logic [2:0] {
    P_OFF = 3'b000,
    P_RUNUP = 3'b001,
    P_AT_SPEED = 3'b010,
    P_STOP_WAIT = 3'b011,
    P_VENT = 3'b100
  } pmon_pump_e;
endpackage : pmon_pkg

// >>> rtl/pmon_top.sv
// Contract
// (RULE1) run off: green flashes; speed classed at or below 60 rpm.
// (RULE2) run on, target not reached: green flashes inverse.
// (RULE3) run on, target reached: green steady.
// (RULE4) yellow steady on warning, red steady on error, else dark.
// (RULE5) warning and error temperature thresholds are fixed constants.
// (RULE6) over warning temperature: derate power, warn, keep motor running.
// (RULE7) derated speed below switchpoint switches the pump off.
// (RULE8) over error temperature: pump off at once, error latched.
// (RULE9) run command survives error shutdown; restart after acknowledge.
// (RULE10) on error pump and peripherals off; venting after preset delay.
// (RULE11) warnings alone leave motor and peripherals running.
// (RULE12) numeric fault code readable; external party reads it.
// (RULE13) external party acknowledges after removing cause; latch clears.
// (RULE14) codes 1,2,7,8,10,21,41 acknowledge only at zero speed.
// (RULE15) run-up timeout below switchpoint raises error 6, no zero-speed need.
// (RULE16) distinct codes for overspeed, voltage, fluid, link, missing, drive.
// (RULE17) after passed self-test, corrected errors clear before starting.
// (RULE18) run cleared: pump off, venting on, backing pump off.
// (RULE19) both flash patterns come from one blink timer, one the inverse.
// (RULE20) all lamps dark while held in reset.
module pmon_top #(
  parameter int TICK_CYCLES = pmon_pkg::TICK_CYCLES,
  parameter int BLINK_CYCLES = pmon_pkg::BLINK_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [15:0] ROTOR_SPEED,
  input wire logic [7:0] TEMP_MOTOR,
  input wire logic [7:0] TEMP_ELEC,
  input wire logic [6:0] FAULT_IN,
  input wire logic SELFTEST_PASS,
  output logic LED_GREEN,
  output logic LED_YELLOW,
  output logic LED_RED,
  output logic MOTOR_EN,
  output logic DERATE,
  output logic PERIPH_EN,
  output logic BACKING_EN,
  output logic VENT_EN
);
  function automatic logic [7:0] err_code(input logic [pmon_pkg::ERR_N-1:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = pmon_pkg::ERR_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        c = pmon_pkg::ERR_CODE[i];
      end
    end
    return c;
  endfunction : err_code

  pmon_pkg::pmon_sense_s meta_r, sense_r;
  logic selftest_d_r, selftest_ok_r;
  logic run_r, ack_r, trip_r, blink_r, derate_r;
  logic [1:0] vmode_r;
  logic [15:0] speed_sw_r, target_r, runup_s_r, vent_s_r, secs_r;
  logic [31:0] tick_cnt_r, blink_cnt_r, rdata_r;
  logic [pmon_pkg::ERR_N-1:0] err_r, cause, clr;
  logic [7:0] addr_r;
  logic wr_r, rd_ph, led_g_r, led_y_r, led_r_r;
  pmon_pkg::pmon_pump_e state_r, state_nxt;
  logic sec_tick, speed_zero, below_sw, hot, warn_any, err_any, go, runup_set;
  logic st_rise, wr_ctrl, ack_stb;

  // input synchroniser
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      meta_r <= '0;
      sense_r <= '0;
      selftest_d_r <= 1'b0;
    end else begin
      meta_r <= {ROTOR_SPEED, TEMP_MOTOR, TEMP_ELEC, FAULT_IN, SELFTEST_PASS};
      sense_r <= meta_r;
      selftest_d_r <= sense_r.selftest;
    end
  end

  assign st_rise = sense_r.selftest & ~selftest_d_r;
  assign speed_zero = (sense_r.speed == pmon_pkg::ZERO_RPM);
  assign below_sw = (sense_r.speed < speed_sw_r);
  assign hot = (sense_r.temp_motor > pmon_pkg::TEMP_ERR_MOTOR) |
               (sense_r.temp_elec > pmon_pkg::TEMP_ERR_ELEC); // RULE5
  assign warn_any = (sense_r.temp_motor > pmon_pkg::TEMP_WARN_MOTOR) |
                    (sense_r.temp_elec > pmon_pkg::TEMP_WARN_ELEC); // RULE5
  assign err_any = |err_r;
  assign go = run_r & ~err_any & selftest_ok_r & ~trip_r; // RULE11

  // ahb-lite slave, zero wait states
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_r;
  assign rd_ph = HSEL & HREADY & HTRANS[1] & ~HWRITE;
  assign wr_ctrl = wr_r & (addr_r == pmon_pkg::ADDR_CTRL);
  assign ack_stb = ack_r;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      wr_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_r <= HSEL & HREADY & HTRANS[1] & HWRITE;
      addr_r <= HADDR[7:0];
    end
  end

  // writable registers
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      run_r <= 1'b0;
      vmode_r <= pmon_pkg::VM_DELAYED;
      speed_sw_r <= pmon_pkg::RST_SPEED_SW;
      target_r <= pmon_pkg::RST_TARGET;
      runup_s_r <= pmon_pkg::RST_RUNUP_S;
      vent_s_r <= pmon_pkg::RST_VENT_S;
      ack_r <= 1'b0;
    end else begin
      ack_r <= wr_r & (addr_r == pmon_pkg::ADDR_ACK) & HWDATA[pmon_pkg::ACK_BIT];
      if (wr_ctrl) begin
        run_r <= HWDATA[pmon_pkg::CTRL_RUN]; // RULE9
        vmode_r <= HWDATA[pmon_pkg::CTRL_VMODE +: 2];
      end
      if (wr_r && addr_r == pmon_pkg::ADDR_SPEED_SW) begin
        speed_sw_r <= HWDATA[15:0];
      end
      if (wr_r && addr_r == pmon_pkg::ADDR_TARGET) begin
        target_r <= HWDATA[15:0];
      end
      if (wr_r && addr_r == pmon_pkg::ADDR_RUNUP) begin
        runup_s_r <= HWDATA[15:0];
      end
      if (wr_r && addr_r == pmon_pkg::ADDR_VENT) begin
        vent_s_r <= HWDATA[15:0];
      end
    end
  end

  // read data captured in the address phase
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_ph) begin
      unique case (HADDR[7:0])
        pmon_pkg::ADDR_CTRL: rdata_r <= {29'h0, vmode_r, run_r};
        pmon_pkg::ADDR_STATUS: rdata_r <= {24'h0, selftest_ok_r, trip_r, derate_r,
                                           warn_any, err_any, speed_zero,
                                           (sense_r.speed <= pmon_pkg::SLOW_RPM),
                                           (state_r == pmon_pkg::P_AT_SPEED)}; // RULE1
        pmon_pkg::ADDR_CODE: rdata_r <= {24'h0, err_code(err_r)}; // RULE12
        pmon_pkg::ADDR_ERRS: rdata_r <= {22'h0, err_r};
        pmon_pkg::ADDR_SPEED_SW: rdata_r <= {16'h0, speed_sw_r};
        pmon_pkg::ADDR_TARGET: rdata_r <= {16'h0, target_r};
        pmon_pkg::ADDR_RUNUP: rdata_r <= {16'h0, runup_s_r};
        pmon_pkg::ADDR_VENT: rdata_r <= {16'h0, vent_s_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // fault latch, set wins over clear
  assign runup_set = (state_r == pmon_pkg::P_RUNUP) & below_sw & sec_tick &
                     (secs_r >= runup_s_r); // RULE15
  always_comb begin
    cause = {(sense_r.temp_motor > pmon_pkg::TEMP_ERR_MOTOR),
             (sense_r.temp_elec > pmon_pkg::TEMP_ERR_ELEC),
             sense_r.fault[6:2], runup_set, sense_r.fault[1:0]}; // RULE16
    clr = '0;
    if (ack_stb || st_rise) begin
      clr = ~cause &
            ~(pmon_pkg::ZERO_ACK_MASK & {pmon_pkg::ERR_N{~speed_zero & ~st_rise}}); // RULE14
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      err_r <= '0;
    end else begin
      err_r <= (err_r & ~clr) | cause; // RULE13 RULE17 RULE8
    end
  end

  // self-test gate
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      selftest_ok_r <= 1'b0;
    end else if (st_rise) begin
      selftest_ok_r <= 1'b1; // RULE17
    end
  end

  // timers
  assign sec_tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
  always_ff @(posedge CLOCK) begin
    if (!RESETN || state_r != state_nxt) begin
      tick_cnt_r <= 32'h0000_0000;
      secs_r <= 16'h0000;
    end else if (sec_tick) begin
      tick_cnt_r <= 32'h0000_0000;
      if (secs_r != 16'hFFFF) begin
        secs_r <= secs_r + 16'h0001;
      end
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r <= 1'b0;
    end else if (blink_cnt_r == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r <= ~blink_r; // RULE19
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
    end
  end

  // derating and switchpoint trip
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      derate_r <= 1'b0;
      trip_r <= 1'b0;
    end else begin
      derate_r <= warn_any; // RULE6
      if (state_r == pmon_pkg::P_AT_SPEED && derate_r && below_sw) begin
        trip_r <= 1'b1; // RULE7
      end else if (!run_r || ack_stb) begin
        trip_r <= 1'b0;
      end
    end
  end

  // pump sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pmon_pkg::P_OFF: if (go) state_nxt = pmon_pkg::P_RUNUP;
      pmon_pkg::P_RUNUP: begin
        if (!go) state_nxt = pmon_pkg::P_STOP_WAIT;
        else if (sense_r.speed >= target_r) state_nxt = pmon_pkg::P_AT_SPEED;
      end
      pmon_pkg::P_AT_SPEED: if (!go) state_nxt = pmon_pkg::P_STOP_WAIT; // RULE18
      pmon_pkg::P_STOP_WAIT: begin
        if (go) state_nxt = pmon_pkg::P_RUNUP;
        else if (vmode_r == pmon_pkg::VM_NONE) state_nxt = pmon_pkg::P_OFF;
        else if (vmode_r == pmon_pkg::VM_DIRECT && secs_r >= pmon_pkg::DIRECT_VENT_S)
          state_nxt = pmon_pkg::P_VENT; // RULE10
        else if (vmode_r != pmon_pkg::VM_DIRECT && secs_r >= vent_s_r)
          state_nxt = pmon_pkg::P_VENT; // RULE10
      end
      pmon_pkg::P_VENT: if (go) state_nxt = pmon_pkg::P_RUNUP;
      default: state_nxt = pmon_pkg::P_OFF;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_r <= pmon_pkg::P_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign MOTOR_EN = (state_r == pmon_pkg::P_RUNUP || state_r == pmon_pkg::P_AT_SPEED) &
                    go; // RULE8 RULE9
  assign PERIPH_EN = run_r & ~err_any; // RULE10 RULE11
  assign BACKING_EN = MOTOR_EN; // RULE18
  assign VENT_EN = (state_r == pmon_pkg::P_VENT); // RULE18
  assign DERATE = derate_r;

  // lamps
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      led_g_r <= 1'b0; // RULE20
      led_y_r <= 1'b0;
      led_r_r <= 1'b0;
    end else begin
      if (!run_r) led_g_r <= blink_r; // RULE1
      else if (state_r == pmon_pkg::P_AT_SPEED) led_g_r <= 1'b1; // RULE3
      else led_g_r <= ~blink_r; // RULE2 RULE19
      led_y_r <= warn_any; // RULE4
      led_r_r <= err_any; // RULE4
    end
  end
  assign LED_GREEN = led_g_r;
  assign LED_YELLOW = led_y_r;
  assign LED_RED = led_r_r;

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  property p_green_off;
    !run_r |=> LED_GREEN == $past(blink_r);
  endproperty
  a_green_off: assert property (p_green_off) else $error("green not flashing"); // RULE1
  property p_green_inv;
    run_r && state_r == pmon_pkg::P_RUNUP |=> LED_GREEN == !$past(blink_r);
  endproperty
  a_green_inv: assert property (p_green_inv) else $error("green not inverse"); // RULE2
  property p_green_on;
    run_r && state_r == pmon_pkg::P_AT_SPEED |=> LED_GREEN;
  endproperty
  a_green_on: assert property (p_green_on) else $error("green not steady"); // RULE3
  property p_lamps;
    1'b1 |=> LED_RED == $past(err_any) && LED_YELLOW == $past(warn_any);
  endproperty
  a_lamps: assert property (p_lamps) else $error("yellow or red wrong"); // RULE4
  property p_derate;
    warn_any ##1 warn_any |-> DERATE;
  endproperty
  a_derate: assert property (p_derate) else $error("no derating"); // RULE6
  sequence s_hot;
    hot;
  endsequence
  sequence s_off_latched;
    err_any && !MOTOR_EN && !PERIPH_EN;
  endsequence
  property p_hot_off;
    s_hot |=> s_off_latched;
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("hot pump not off"); // RULE8
  property p_run_kept;
    err_any && !wr_ctrl |=> run_r == $past(run_r);
  endproperty
  a_run_kept: assert property (p_run_kept) else $error("run lost on error"); // RULE9
  property p_err_periph;
    err_any |-> !PERIPH_EN && !MOTOR_EN;
  endproperty
  a_err_periph: assert property (p_err_periph) else $error("error left outputs on"); // RULE10
  property p_zero_ack;
    ack_stb && !speed_zero && !st_rise && err_r[pmon_pkg::E_OVERSPEED] |=>
      err_r[pmon_pkg::E_OVERSPEED];
  endproperty
  a_zero_ack: assert property (p_zero_ack) else $error("ack taken at speed"); // RULE14
  property p_runup_ack;
    ack_stb && err_r[pmon_pkg::E_RUNUP] && !runup_set |=> !err_r[pmon_pkg::E_RUNUP];
  endproperty
  a_runup_ack: assert property (p_runup_ack) else $error("run-up error kept"); // RULE15
  property p_reset_dark;
    disable iff (1'b0) !RESETN |=> !LED_GREEN && !LED_YELLOW && !LED_RED;
  endproperty
  a_reset_dark: assert property (p_reset_dark) else $error("lamp lit in reset"); // RULE20
endmodule : pmon_top

// >>> bench/pmon_pump_model.sv
module pmon_pump_model #(
  parameter logic [15:0] TOP = 16'h0190,
  parameter logic [15:0] STEP = 16'h0008
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic motor_en,
  input wire logic derate,
  input wire logic hold,
  input wire logic [15:0] hold_val,
  output logic [15:0] speed
);
  timeunit 1ns;
  timeprecision 1ps;
  // rotor spins up while driven, coasts down when derated or off
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      speed <= 16'h0000;
    end else if (hold) begin
      speed <= hold_val;
    end else if (motor_en && !derate) begin
      speed <= (speed > TOP - STEP) ? TOP : speed + STEP;
    end else begin
      speed <= (speed < STEP) ? 16'h0000 : speed - STEP;
    end
  end
endmodule : pmon_pump_model

// >>> bench/pump_status_fault_monitor_test.sv
module pump_status_fault_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 20;
  localparam logic [7:0] CODES [7] = '{8'h01, 8'h02, 8'h07, 8'h08, 8'h0A, 8'h15, 8'h29};
  localparam logic [1:0] VM [3] = '{pmon_pkg::VM_DELAYED, pmon_pkg::VM_DIRECT, pmon_pkg::VM_NONE};
  localparam int DL [3] = '{2, 6, 9};
  logic CLOCK = 1'b0;
  logic RESETN = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA, q;
  logic HREADYOUT, HRESP, g, y, r, men, der, pen, ben, ven;
  logic [15:0] spd;
  logic [15:0] hval = 16'h0000;
  logic hold = 1'b1;
  logic [7:0] tm = 8'h20;
  logic [7:0] te = 8'h20;
  logic [6:0] flt = 7'h00;
  logic st = 1'b0;
  int n_errors = 0;
  int check_count = 0;
  int wc;
  always #2.5 CLOCK = ~CLOCK;
  pmon_top #(.TICK_CYCLES(T), .BLINK_CYCLES(4)) DUT (
    .CLOCK(CLOCK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ROTOR_SPEED(spd), .TEMP_MOTOR(tm), .TEMP_ELEC(te),
    .FAULT_IN(flt), .SELFTEST_PASS(st), .LED_GREEN(g), .LED_YELLOW(y), .LED_RED(r),
    .MOTOR_EN(men), .DERATE(der), .PERIPH_EN(pen), .BACKING_EN(ben), .VENT_EN(ven)
  );
  pmon_pump_model pump (
    .clk(CLOCK), .rst_n(RESETN), .motor_en(men), .derate(der), .hold(hold),
    .hold_val(hval), .speed(spd)
  );
  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
  endtask : cyc
  // latched vector bit of fault input i; bit 2 is the run-up error
  function automatic logic [31:0] errs_bit(input int i);
    return 32'h1 << ((i < 2) ? i : i + 1);
  endfunction : errs_bit
  task automatic rdy();
    @(posedge CLOCK);
    while (HREADYOUT !== 1'b1) @(posedge CLOCK);
  endtask : rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    rdy();
    HTRANS <= 2'h0;
    HWDATA <= d;
    rdy();
    q = HRDATA;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask : rd
  task automatic ack();
    bus(1'b1, pmon_pkg::ADDR_ACK, 32'h1);
    cyc(3);
  endtask : ack
  task automatic wt(ref logic s, input logic v, input int n);
    wc = 0;
    while (s !== v && wc < n) begin
      @(posedge CLOCK);
      wc++;
    end
  endtask : wt
  task automatic gcount(input int e);
    int n;
    n = 0;
    repeat (16) begin
      @(posedge CLOCK);
      n += int'(g === 1'b1);
    end
    chk("green ones", n, e);
  endtask : gcount
  initial begin
    #40000;
    n_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(72));
    cyc(12);
    chk("lamps in reset", {g, y, r, men}, 4'h0);
    RESETN <= 1'b1;
    cyc(1);
    rd(pmon_pkg::ADDR_SPEED_SW, 32'h2EE0, "switchpoint");
    bus(1'b1, 8'h24, 32'hFFFF_FFFF);
    rd(8'h24, 32'h0, "unmapped");
    chk("hresp", HRESP, 1'b0);
    chk("hready", HREADYOUT, 1'b1);
    bus(1'b1, pmon_pkg::ADDR_SPEED_SW, 32'h64);
    bus(1'b1, pmon_pkg::ADDR_TARGET, 32'hC8);
    bus(1'b1, pmon_pkg::ADDR_RUNUP, 32'h3);
    bus(1'b1, pmon_pkg::ADDR_VENT, 32'h2);
    hval <= 16'h003C;
    cyc(4);
    rd(pmon_pkg::ADDR_STATUS, 32'h2, "slow at 60");
    gcount(8);
    hval <= 16'h003D;
    cyc(4);
    rd(pmon_pkg::ADDR_STATUS, 32'h0, "above 60");
    chk("dark", {y, r}, 2'h0);
    for (int i = 0; i < 7; i++) begin
      te <= 8'h10 + 8'($urandom % 32);
      hval <= 16'h0001 + 16'($urandom % 300);
      flt <= 7'h01 << i;
      cyc(6);
      chk("red", r, 1'b1);
      rd(pmon_pkg::ADDR_CODE, CODES[i], "code");
      flt <= 7'h00;
      cyc(4);
      ack();
      rd(pmon_pkg::ADDR_ERRS, errs_bit(i), "kept");
      hval <= 16'h0000;
      cyc(4);
      ack();
      rd(pmon_pkg::ADDR_ERRS, 32'h0, "cleared");
    end
    hval <= 16'h0050;
    flt <= 7'h40;
    cyc(6);
    flt <= 7'h00;
    cyc(4);
    st <= 1'b1;
    cyc(6);
    rd(pmon_pkg::ADDR_ERRS, 32'h0, "selftest clear");
    hold <= 1'b0;
    bus(1'b1, pmon_pkg::ADDR_CTRL, 32'h3);
    wt(men, 1'b1, 10);
    gcount(8);
    cyc(40);
    gcount(16);
    bus(1'b0, pmon_pkg::ADDR_STATUS, 32'h0);
    chk("at target", q[0], 1'b1);
    tm <= 8'h50;
    cyc(6);
    chk("no derate at limit", der, 1'b0);
    tm <= 8'h51;
    cyc(6);
    chk("warn run", {der, y, r, men, pen}, 5'h1B);
    wt(men, 1'b0, 100);
    chk("trip", wc < 100, 1'b1);
    bus(1'b0, pmon_pkg::ADDR_STATUS, 32'h0);
    chk("trip flag", q[6], 1'b1);
    tm <= 8'h30;
    cyc(4);
    ack();
    wt(men, 1'b1, 10);
    chk("restart", men, 1'b1);
    cyc(60);
    te <= 8'h51;
    tm <= 8'h5B;
    cyc(6);
    chk("err stop", {men, pen, ben, r}, 4'h1);
    rd(pmon_pkg::ADDR_CODE, 32'h2C, "temp code");
    rd(pmon_pkg::ADDR_ERRS, 32'h300, "both temps");
    rd(pmon_pkg::ADDR_CTRL, 32'h3, "run kept");
    te <= 8'h20;
    tm <= 8'h30;
    cyc(4);
    ack();
    wt(men, 1'b1, 10);
    chk("auto restart", {men, r}, 2'h2);
    bus(1'b1, pmon_pkg::ADDR_CTRL, 32'h2);
    hval <= 16'h0032;
    hold <= 1'b1;
    cyc(4);
    bus(1'b1, pmon_pkg::ADDR_CTRL, 32'h3);
    wt(r, 1'b1, 5 * T);
    chk("runup time", wc >= 2 * T && wc <= 4 * T + 6, 1'b1);
    rd(pmon_pkg::ADDR_CODE, 32'h06, "runup code");
    ack();
    rd(pmon_pkg::ADDR_ERRS, 32'h0, "runup ack");
    hold <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, pmon_pkg::ADDR_CTRL, {29'h0, VM[m], 1'b1});
      cyc(60);
      bus(1'b1, pmon_pkg::ADDR_CTRL, {29'h0, VM[m], 1'b0});
      cyc(2);
      chk("stopped", {men, ben, pen}, 3'h0);
      wt(ven, 1'b1, 8 * T);
      chk("vent delay", wc >= (DL[m] - 1) * T && wc <= DL[m] * T + 6, 1'b1);
    end
    RESETN <= 1'b0;
    cyc(2);
    chk("lamps reset", {g, y, r, men, ven}, 5'h0);
    complete_run();
  end
endmodule : pump_status_fault_monitor_test
